// file: hdl/tmw_cfg.svh
// register offsets, field positions, reset values and fixed tops of the waveform timer
`ifndef TMW_CFG_SVH
`define TMW_CFG_SVH
`define TMW_ADDR_W 4
`define TMW_OFS_CTRL 4'h0
`define TMW_OFS_COUNT 4'h1
`define TMW_OFS_COMPARE_A 4'h2
`define TMW_OFS_COMPARE_B 4'h3
`define TMW_OFS_CAPTURE 4'h4
`define TMW_OFS_FLAGS 4'h5
`define TMW_OFS_PIN_DIR 4'h6
`define TMW_CTRL_MODE_LSB 0
`define TMW_CTRL_SEL_A_LSB 4
`define TMW_CTRL_SEL_B_LSB 6
`define TMW_FLAG_OVF 0
`define TMW_FLAG_CMP_A 1
`define TMW_FLAG_CMP_B 2
`define TMW_FLAG_CAP 3
`define TMW_RST_MODE 4'h0
`define TMW_RST_SEL 2'h0
`define TMW_RST_WORD 16'h0000
`define TMW_RST_FLAGS 4'h0
`define TMW_RST_PIN_DIR 2'h0
`define TMW_TOP_8BIT 16'h00FF
`define TMW_TOP_9BIT 16'h01FF
`define TMW_TOP_10BIT 16'h03FF
`define TMW_MAX 16'hFFFF
`define TMW_BOTTOM 16'h0000
`define TMW_SEL_TOGGLE 2'h1
`define TMW_SEL_CLEAR 2'h2
`define TMW_SEL_SET 2'h3
`endif

// file: hdl/tmw_ch_if.sv
// per-channel carrier between the timer core and an output unit
`timescale 1ns/10ps
interface tmw_ch_if;
   import tmw_pkg::*;
   logic tick; // prescaled timer enable
   logic match; // count equals this channel's compare value
   logic restart; // count at top in fast mode, cleared next
   logic dir_up; // dual slope direction
   tmw_class_t cls; // counting class
   logic [1:0] sel; // output action select
   logic toggle_ok; // toggle allowed in this mode and channel
   logic state; // internal output state bit
   modport ctl (output tick, match, restart, dir_up, cls, sel, toggle_ok, input state);
   modport unit (input tick, match, restart, dir_up, cls, sel, toggle_ok, output state);
endinterface : tmw_ch_if

// file: hdl/tmw_out_unit.sv
// compare output state for one channel
`timescale 1ns/10ps
`include "tmw_cfg.svh"
module tmw_out_unit (
   input wire logic clk_sys,
   input wire logic rst_b,
   tmw_ch_if.unit ch
);
   import tmw_pkg::*;

   logic state; // output state bit
   logic next_state; // value at next timer tick

   // action decode per class
   always_comb begin
      next_state = state;
      case (ch.cls)
         TMW_FAST: begin
            // bottom wins over a match at top, so compare equal to top gives a steady level
            if (ch.restart && ch.sel[1]) begin
               next_state = ~ch.sel[0];
            end else if (ch.match) begin
               if (ch.sel == `TMW_SEL_TOGGLE && ch.toggle_ok) begin
                  next_state = ~state;
               end else if (ch.sel[1]) begin
                  next_state = ch.sel[0];
               end
            end
         end
         TMW_PHASE: begin
            if (ch.match) begin
               if (ch.sel == `TMW_SEL_TOGGLE && ch.toggle_ok) begin
                  next_state = ~state;
               end else if (ch.sel[1]) begin
                  // up slope clears when non-inverting, down slope sets
                  next_state = ch.sel[0] ~^ ch.dir_up;
               end
            end
         end
         default: begin
            // normal and clear-on-match: toggle, clear or set on match
            if (ch.match) begin
               case (ch.sel)
                  `TMW_SEL_TOGGLE: next_state = ~state;
                  `TMW_SEL_CLEAR: next_state = 1'b0;
                  `TMW_SEL_SET: next_state = 1'b1;
                  default: next_state = state;
               endcase
            end
         end
      endcase
   end

   // state moves only on timer ticks
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= 1'b0;
      end else if (ch.tick) begin
         state <= next_state;
      end
   end

   assign ch.state = state;
endmodule : tmw_out_unit

// file: hdl/tmw_pkg.sv
// types shared by the waveform timer modules
package tmw_pkg;
   // counting behaviour class decoded from the waveform select code
   typedef enum logic [1:0] {
      TMW_NORMAL = 2'b00,
      TMW_CTC = 2'b01,
      TMW_FAST = 2'b10,
      TMW_PHASE = 2'b11
   } tmw_class_t;
endpackage : tmw_pkg

// file: hdl/tmw_timer.sv
// 16-bit timer with clear-on-match, fast and phase correct waveform generation
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "tmw_cfg.svh"
module tmw_timer (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic tick_en,
   input wire logic [`TMW_ADDR_W-1:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rd_data,
   output logic overflow_flag,
   output logic compare_a_flag,
   output logic compare_b_flag,
   output logic capture_flag,
   output logic [1:0] wave_pin_out,
   output logic [1:0] wave_pin_oe_b
);
   import tmw_pkg::*;

   localparam int NCH = 2; // compare channels

   logic [3:0] waveform_sel; // mode code
   logic [1:0] output_action_sel [NCH]; // per-channel action select
   logic [15:0] count_value; // counter
   logic count_up; // dual slope direction
   logic [15:0] compare_value [NCH]; // active compare registers
   logic [15:0] compare_buf [NCH]; // software side buffers
   logic [15:0] capture_value; // capture register, used as top
   logic [3:0] flags; // sticky event flags
   logic [1:0] pin_dir; // data direction bits
   logic [15:0] top_val; // current top
   logic at_top; // count equals top
   logic [3:0] flag_set; // events this cycle
   logic [3:0] flag_clr; // software clears this cycle
   tmw_class_t cls; // decoded class
   logic pwm; // buffered compare modes
   logic [15:0] next_count; // counter next value
   logic next_up; // direction next value

   // counting class of a mode code
   function automatic tmw_class_t class_of(input logic [3:0] m);
      case (m)
         4'h4, 4'hC: class_of = TMW_CTC;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = TMW_FAST;
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: class_of = TMW_PHASE;
         default: class_of = TMW_NORMAL; // unsupported codes run as normal
      endcase
   endfunction : class_of

   // fixed top of a mode, or max when the top is not fixed
   function automatic logic [15:0] fixed_top(input logic [3:0] m);
      case (m)
         4'h1, 4'h5: fixed_top = `TMW_TOP_8BIT;
         4'h2, 4'h6: fixed_top = `TMW_TOP_9BIT;
         4'h3, 4'h7: fixed_top = `TMW_TOP_10BIT;
         default: fixed_top = `TMW_MAX;
      endcase
   endfunction : fixed_top

   // top taken from the capture register
   function automatic logic capture_is_top(input logic [3:0] m);
      capture_is_top = (m == 4'hC) || (m == 4'hE) || (m == 4'hA);
   endfunction : capture_is_top

   // top taken from compare A
   function automatic logic compare_a_is_top(input logic [3:0] m);
      compare_a_is_top = (m == 4'h4) || (m == 4'hF) || (m == 4'hB);
   endfunction : compare_a_is_top

   assign cls = class_of(waveform_sel);
   assign pwm = (cls == TMW_FAST) || (cls == TMW_PHASE);

   // top selection; capture and mode 4 compare tops act at once, compare A tops of modes F and B at the next top
   always_comb begin
      if (compare_a_is_top(waveform_sel)) begin
         top_val = compare_value[0];
      end else if (capture_is_top(waveform_sel)) begin
         top_val = capture_value;
      end else begin
         top_val = fixed_top(waveform_sel);
      end
   end

   assign at_top = (count_value == top_val);

   // counter sequence per class
   always_comb begin
      next_count = count_value + 16'h0001;
      next_up = count_up;
      case (cls)
         TMW_CTC: begin
            // a top below the count is passed by, wrapping at max
            if (at_top) begin
               next_count = `TMW_BOTTOM;
            end
         end
         TMW_FAST: begin
            if (at_top) begin
               next_count = `TMW_BOTTOM;
            end
         end
         TMW_PHASE: begin
            if (count_up) begin
               // top seen for one tick, then turn
               if (at_top) begin
                  next_count = count_value - 16'h0001;
                  next_up = 1'b0;
               end
            end else if (count_value == `TMW_BOTTOM) begin
               next_up = 1'b1;
            end else begin
               next_count = count_value - 16'h0001;
            end
         end
         default: next_count = count_value + 16'h0001;
      endcase
   end

   // counter and direction; a software write to the count wins over a tick
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_value <= `TMW_RST_WORD;
         count_up <= 1'b1;
      end else if (wr_en && addr == `TMW_OFS_COUNT) begin
         count_value <= wr_data;
      end else if (tick_en) begin
         count_value <= next_count;
         count_up <= pwm ? next_up : 1'b1;
      end
   end

   // control, capture and direction registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         waveform_sel <= `TMW_RST_MODE;
         output_action_sel[0] <= `TMW_RST_SEL;
         output_action_sel[1] <= `TMW_RST_SEL;
         capture_value <= `TMW_RST_WORD;
         pin_dir <= `TMW_RST_PIN_DIR;
      end else if (wr_en) begin
         case (addr)
            `TMW_OFS_CTRL: begin
               waveform_sel <= wr_data[`TMW_CTRL_MODE_LSB +: 4];
               output_action_sel[0] <= wr_data[`TMW_CTRL_SEL_A_LSB +: 2];
               output_action_sel[1] <= wr_data[`TMW_CTRL_SEL_B_LSB +: 2];
            end
            `TMW_OFS_CAPTURE: capture_value <= wr_data; // never buffered
            `TMW_OFS_PIN_DIR: pin_dir <= wr_data[1:0];
            default: ;
         endcase
      end
   end

   // compare registers: buffered in pwm classes, direct otherwise
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NCH; i++) begin
            compare_value[i] <= `TMW_RST_WORD;
            compare_buf[i] <= `TMW_RST_WORD;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_en && addr == (`TMW_OFS_COMPARE_A + 4'(i))) begin
               compare_buf[i] <= wr_data & fixed_top(waveform_sel);
               if (!pwm) begin
                  compare_value[i] <= wr_data & fixed_top(waveform_sel);
               end
            end
            if (pwm && tick_en && at_top) begin
               compare_value[i] <= compare_buf[i];
            end
         end
      end
   end

   // event detection on timer ticks
   always_comb begin
      flag_set = 4'h0;
      if (tick_en) begin
         case (cls)
            TMW_FAST: flag_set[`TMW_FLAG_OVF] = at_top;
            TMW_PHASE: flag_set[`TMW_FLAG_OVF] = !count_up && count_value == `TMW_BOTTOM;
            default: flag_set[`TMW_FLAG_OVF] = (count_value == `TMW_MAX);
         endcase
         flag_set[`TMW_FLAG_CMP_A] = (count_value == compare_value[0]);
         flag_set[`TMW_FLAG_CMP_B] = (count_value == compare_value[1]);
         flag_set[`TMW_FLAG_CAP] = capture_is_top(waveform_sel) && at_top;
      end
   end

   assign flag_clr = (wr_en && addr == `TMW_OFS_FLAGS) ? wr_data[3:0] : 4'h0;

   // sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flags <= `TMW_RST_FLAGS;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // flag outputs registered beside the flags
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         overflow_flag <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
         capture_flag <= 1'b0;
      end else begin
         overflow_flag <= (flags[`TMW_FLAG_OVF] & ~flag_clr[`TMW_FLAG_OVF]) | flag_set[0];
         compare_a_flag <= (flags[`TMW_FLAG_CMP_A] & ~flag_clr[1]) | flag_set[1];
         compare_b_flag <= (flags[`TMW_FLAG_CMP_B] & ~flag_clr[2]) | flag_set[2];
         capture_flag <= (flags[`TMW_FLAG_CAP] & ~flag_clr[3]) | flag_set[3];
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= `TMW_RST_WORD;
      end else if (rd_en) begin
         case (addr)
            `TMW_OFS_CTRL: rd_data <= {8'h00, output_action_sel[1], output_action_sel[0],
                                       waveform_sel};
            `TMW_OFS_COUNT: rd_data <= count_value;
            `TMW_OFS_COMPARE_A: rd_data <= compare_buf[0];
            `TMW_OFS_COMPARE_B: rd_data <= compare_buf[1];
            `TMW_OFS_CAPTURE: rd_data <= capture_value;
            `TMW_OFS_FLAGS: rd_data <= {12'h000, flags};
            `TMW_OFS_PIN_DIR: rd_data <= {14'h0000, pin_dir};
            default: rd_data <= `TMW_RST_WORD; // unmapped reads zero
         endcase
      end else begin
         rd_data <= `TMW_RST_WORD;
      end
   end

   tmw_ch_if ch [NCH] (); // channel carriers

   // one output unit per channel
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_ch
         assign ch[g].tick = tick_en;
         assign ch[g].match = (count_value == compare_value[g]);
         assign ch[g].restart = (cls == TMW_FAST) && at_top;
         assign ch[g].dir_up = count_up;
         assign ch[g].cls = cls;
         assign ch[g].sel = output_action_sel[g];
         // pwm toggle only on channel A with compare A as top
         assign ch[g].toggle_ok = (g == 0) && compare_a_is_top(waveform_sel);

         tmw_out_unit u_out (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .ch(ch[g])
         );

         // pin driven only with direction set and an action selected
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               wave_pin_out[g] <= 1'b0;
               wave_pin_oe_b[g] <= 1'b1;
            end else begin
               wave_pin_out[g] <= ch[g].state;
               wave_pin_oe_b[g] <= ~(pin_dir[g] && output_action_sel[g] != 2'h0);
            end
         end
      end
   endgenerate
endmodule : tmw_timer

// file: verification/tb_tmw_timer.sv
// self-checking bench for the waveform timer
`timescale 1ns/10ps
`include "tmw_cfg.svh"
module tb_tmw_timer;
   logic clk_sys = 1'b0; // 50 MHz system clock
   logic rst_b = 1'b1; // pulled low at time zero, held low for 8 cycles
   logic tick_en = 1'b0; // pulsed only by tick
   logic [3:0] addr = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] rd_data;
   logic overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
   logic [1:0] wave_pin_out, wave_pin_oe_b;
   logic [15:0] top; // fixed top of the mode under test
   int n_fail = 0; // mismatches
   int tests_run = 0; // comparisons made
   int cyc = 0; // cycles since start, for the hang limit

   always #10 clk_sys = ~clk_sys;

   tmw_timer dut (.clk_sys(clk_sys), .rst_b(rst_b), .tick_en(tick_en), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
      .compare_b_flag(compare_b_flag), .capture_flag(capture_flag),
      .wave_pin_out(wave_pin_out), .wave_pin_oe_b(wave_pin_oe_b));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one-cycle write, then a quiet edge so strobes never re-arm in one step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   // data stands only in the cycle after the strobe edge
   task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk(name, exp, rd_data);
      @(posedge clk_sys);
   endtask : rd_chk

   // n timer ticks, then time for flags and pins to land
   task automatic tick(input int n);
      tick_en <= 1'b1;
      repeat (n) @(posedge clk_sys);
      tick_en <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : tick

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // hang limit, far above the fewer than 900 cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   initial begin
      rst_b <= 1'b0; // a real falling edge, so the asynchronous resets act
      repeat (8) @(posedge clk_sys);
      chk("rst_pins", 16'h0000, {14'h0, wave_pin_out});
      chk("rst_oe", 16'h0003, {14'h0, wave_pin_oe_b});
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd_chk("unmapped", 4'hF, 16'h0000);
      // clear on match at compare a, toggling channel a
      wr(`TMW_OFS_COMPARE_A, 16'h0003);
      wr(`TMW_OFS_PIN_DIR, 16'h0001);
      wr(`TMW_OFS_CTRL, 16'h0014);
      tick(4);
      rd_chk("ctc_count", `TMW_OFS_COUNT, 16'h0000);
      chk("ctc_pin", 16'h0001, {14'h0, wave_pin_out});
      chk("ctc_oe", 16'h0002, {14'h0, wave_pin_oe_b});
      rd_chk("ctc_flags", `TMW_OFS_FLAGS, 16'h0006);
      chk("ctc_cmpa_out", 16'h0001, {15'h0, compare_a_flag});
      chk("ctc_cmpb_out", 16'h0001, {15'h0, compare_b_flag});
      tick(4);
      chk("ctc_pin2", 16'h0000, {14'h0, wave_pin_out});
      wr(`TMW_OFS_PIN_DIR, 16'h0000);
      // the enable is registered one edge behind the direction bit
      @(posedge clk_sys);
      chk("oe_off", 16'h0003, {14'h0, wave_pin_oe_b});
      // capture as top: a missed top wraps through the maximum
      wr(`TMW_OFS_CAPTURE, 16'h0005);
      wr(`TMW_OFS_CTRL, 16'h000C);
      wr(`TMW_OFS_FLAGS, 16'h000F);
      wr(`TMW_OFS_COUNT, 16'hFFFE);
      tick(2);
      rd_chk("wrap_count", `TMW_OFS_COUNT, 16'h0000);
      chk("wrap_ovf", 16'h0001, {15'h0, overflow_flag});
      tick(6);
      rd_chk("cap_top", `TMW_OFS_COUNT, 16'h0000);
      wr(`TMW_OFS_CAPTURE, 16'h0003);
      tick(4);
      rd_chk("cap_new_top", `TMW_OFS_COUNT, 16'h0000);
      // fast modes with fixed tops, non-inverting channel a
      for (int i = 0; i < 3; i++) begin
         top = (16'h0100 << i) - 16'h0001;
         wr(`TMW_OFS_CTRL, 16'h0025 + 16'(i));
         wr(`TMW_OFS_COMPARE_A, 16'hFFFF);
         rd_chk("mask", `TMW_OFS_COMPARE_A, top);
         wr(`TMW_OFS_FLAGS, 16'h000F);
         wr(`TMW_OFS_COUNT, top - 16'h0001);
         tick(2);
         rd_chk("fast_wrap", `TMW_OFS_COUNT, 16'h0000);
         chk("fast_ovf", 16'h0001, {15'h0, overflow_flag});
         chk("fast_set", 16'h0001, {15'h0, wave_pin_out[0]});
      end
      // a buffered compare must not act before the next top
      wr(`TMW_OFS_CTRL, 16'h0025);
      wr(`TMW_OFS_COUNT, 16'h0005);
      wr(`TMW_OFS_COMPARE_A, 16'h0010);
      tick(16);
      chk("buf_hold", 16'h0001, {15'h0, wave_pin_out[0]});
      wr(`TMW_OFS_COUNT, 16'h00FE);
      tick(18);
      chk("pre_match", 16'h0001, {15'h0, wave_pin_out[0]});
      tick(1);
      chk("fast_clear", 16'h0000, {15'h0, wave_pin_out[0]});
      // phase correct, fixed top 0xFF, compare a at 0x80
      wr(`TMW_OFS_CTRL, 16'h0021);
      wr(`TMW_OFS_COMPARE_A, 16'h0080);
      wr(`TMW_OFS_COUNT, 16'h00FD);
      tick(2);
      rd_chk("pc_top", `TMW_OFS_COUNT, 16'h00FF);
      tick(1);
      rd_chk("pc_turn", `TMW_OFS_COUNT, 16'h00FE);
      wr(`TMW_OFS_FLAGS, 16'h000F);
      tick(254);
      rd_chk("pc_bottom", `TMW_OFS_COUNT, 16'h0000);
      chk("pc_down_set", 16'h0001, {15'h0, wave_pin_out[0]});
      tick(129);
      chk("pc_up_clear", 16'h0000, {15'h0, wave_pin_out[0]});
      chk("pc_ovf", 16'h0001, {15'h0, overflow_flag});
      repeat (5) @(posedge clk_sys);
      rd_chk("idle_count", `TMW_OFS_COUNT, 16'h0081);
      // fast with capture as top: overflow and capture flag in one tick
      wr(`TMW_OFS_CAPTURE, 16'h0090);
      wr(`TMW_OFS_CTRL, 16'h002E);
      wr(`TMW_OFS_FLAGS, 16'h000F);
      wr(`TMW_OFS_COUNT, 16'h008F);
      tick(2);
      rd_chk("cap_fast_wrap", `TMW_OFS_COUNT, 16'h0000);
      chk("cap_fast_flag", 16'h0001, {15'h0, capture_flag});
      chk("cap_fast_ovf", 16'h0001, {15'h0, overflow_flag});
      // compare a as top: toggle on channel a, zero compare spike on channel b
      wr(`TMW_OFS_CTRL, 16'h009F);
      wr(`TMW_OFS_FLAGS, 16'h000F);
      tick(129);
      chk("tgl_first", 16'h0000, {15'h0, wave_pin_out[0]});
      chk("tgl_top_flag", 16'h0001, {15'h0, compare_a_flag});
      chk("spike_set", 16'h0001, {15'h0, wave_pin_out[1]});
      tick(1);
      chk("spike_end", 16'h0000, {15'h0, wave_pin_out[1]});
      tick(128);
      chk("tgl_second", 16'h0001, {15'h0, wave_pin_out[0]});
      report_and_stop();
   end
endmodule : tb_tmw_timer

bind tmw_timer tmw_timer_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .tick_en(tick_en),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
   .capture_flag(capture_flag), .wave_pin_out(wave_pin_out), .wave_pin_oe_b(wave_pin_oe_b));

// file: verification/tmw_timer_chk.sv
// port-level assertions for the waveform timer
`timescale 1ns/10ps
`include "tmw_cfg.svh"
module tmw_timer_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic tick_en,
   input wire logic [`TMW_ADDR_W-1:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rd_data,
   input wire logic overflow_flag,
   input wire logic compare_a_flag,
   input wire logic capture_flag,
   input wire logic [1:0] wave_pin_out,
   input wire logic [1:0] wave_pin_oe_b
);
   logic [1:0] dir_seen; // last pin direction written
   logic [2:0] tick_hist; // ticks of the last three edges

   // shadow of the direction register, written only by software
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dir_seen <= 2'h0;
      end else if (wr_en && addr == `TMW_OFS_PIN_DIR) begin
         dir_seen <= wr_data[1:0];
      end
   end

   // flags and pins lag a tick by up to three edges
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_hist <= 3'h0;
      end else begin
         tick_hist <= {tick_hist[1:0], tick_en};
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_ovf_after_tick: assert property ($rose(overflow_flag) |-> |tick_hist)
      else $error("overflow flag rose without a tick");
   a_cmpa_after_tick: assert property ($rose(compare_a_flag) |-> |tick_hist)
      else $error("compare a flag rose without a tick");
   a_cap_after_tick: assert property ($rose(capture_flag) |-> |tick_hist)
      else $error("capture flag rose without a tick");
   a_pin_after_tick: assert property ($changed(wave_pin_out) |-> |tick_hist)
      else $error("output state moved without a tick");
   a_oe_needs_dir_a: assert property (!wave_pin_oe_b[0] |->
      dir_seen[0] || $past(dir_seen[0]))
      else $error("pin a driven with direction clear");
   a_oe_needs_dir_b: assert property (!wave_pin_oe_b[1] |->
      dir_seen[1] || $past(dir_seen[1]))
      else $error("pin b driven with direction clear");
   a_reset_pins_low: assert property (disable iff (1'b0) !rst_b |-> wave_pin_out == 2'h0)
      else $error("output state not cleared in reset");
   // the flag output drops at the very edge that takes the clearing write
   a_ovf_holds: assert property ($fell(overflow_flag) |->
      $past(wr_en && addr == `TMW_OFS_FLAGS && wr_data[`TMW_FLAG_OVF]))
      else $error("overflow flag dropped without a clear");
   a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
      else $error("read data not zero outside a read");
endmodule : tmw_timer_chk
